// ==== ppc_ctrl.sv ====
/*
 * ppc_ctrl: set-point handling, profile generation and status for the
 * profile position operating mode.
 * Assumes: all inputs synchronous to clk; the command word and objects
 * are written by a fieldbus master and held between writes.
 */
`timescale 1ns/100ps
`default_nettype none

module ppc_ctrl #(
	parameter int TICK_CYCLES = ppc_pkg::TICK_CYCLES
) (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// master command objects
	input wire logic [7:0] operating_mode_select,
	input wire logic [15:0] control_word,
	input wire ppc_pkg::ppc_move_t setpoint_in,
	input wire ppc_pkg::ppc_cfg_t cfg,
	// feedback
	input wire logic signed [31:0] actual_pos,
	// status and profile outputs
	output ppc_pkg::ppc_status_t status,
	output logic signed [31:0] demand_pos,
	output logic [31:0] demand_speed,
	output logic start_clear
);
	import ppc_pkg::*;

	// ------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------
	typedef struct packed {
		logic mode_on;
		logic start_prev;
		logic busy;
		logic pend_valid;
		ppc_move_t cur;
		ppc_move_t pend;
		logic signed [31:0] pos;
		logic signed [31:0] base;
		logic [31:0] speed;
		logic [31:0] accel_now;
		logic braking;
		logic dir;
		logic ack;
		logic reached;
		logic limit_hit;
		logic fe;
		logic [31:0] win_cnt;
		logic [31:0] fe_cnt;
		logic start_clear;
	} ppc_state_t;

	ppc_state_t s;
	ppc_state_t next_s;
	logic tick;

	// ------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------
	function automatic logic [31:0] umin(input logic [31:0] a, input logic [31:0] b);
		return (a < b) ? a : b;
	endfunction

	function automatic logic [31:0] dist_of(input logic signed [31:0] a,
		input logic signed [31:0] b);
		logic signed [32:0] d;
		d = {a[31], a} - {b[31], b};
		return d[32] ? 32'(-d) : d[31:0];
	endfunction

	function automatic logic outside(input logic signed [31:0] p, input ppc_cfg_t c);
		return (p < c.limit_min) || (p > c.limit_max);
	endfunction

	// application cycle pulse
	ppc_tick #(
		.CYCLES(TICK_CYCLES)
	) u_tick (
		.clk(clk),
		.sys_rst(sys_rst),
		.tick(tick)
	);

	// ------------------------------------------------------------------
	// next state
	// ------------------------------------------------------------------
	always_comb
	begin
		logic mode_now;
		logic start_edge;
		logic halt;
		logic imm;
		logic [1:0] clr_mode;
		logic signed [31:0] rel_base;
		ppc_move_t nm;
		logic [31:0] vlim;
		logic [31:0] acc_lim;
		logic [31:0] dec_lim;
		logic [31:0] vend;
		logic [31:0] rem;
		logic want_dir;
		logic brake;
		logic [65:0] lhs;
		logic [65:0] rhs;
		logic [31:0] a_want;
		logic [31:0] a_now;
		logic [31:0] jstep;
		logic [32:0] sum;
		logic [31:0] nspeed;
		mode_now = 1'b0;
		start_edge = 1'b0;
		halt = 1'b0;
		imm = 1'b0;
		clr_mode = CLR_NONE;
		rel_base = '0;
		nm = '0;
		vlim = '0;
		acc_lim = '0;
		dec_lim = '0;
		vend = '0;
		rem = '0;
		want_dir = 1'b0;
		brake = 1'b0;
		lhs = '0;
		rhs = '0;
		a_want = '0;
		a_now = '0;
		jstep = '0;
		sum = '0;
		nspeed = '0;

		next_s = s;
		next_s.start_clear = 1'b0;

		// mode and command decode
		mode_now = (operating_mode_select == MODE_PROFILE_POS);
		halt = control_word[CW_HALT];
		imm = control_word[CW_IMMEDIATE];
		clr_mode = cfg.pos_opt[POC_CLR_LSB +: 2];
		// edge, or level already high on mode entry
		start_edge = mode_now && control_word[CW_START]
			&& (!s.start_prev || !s.mode_on);

		// relative reference selection
		unique case (cfg.pos_opt[POC_REL_LSB +: 2])
			REL_DEMAND: rel_base = s.pos;
			REL_ACTUAL: rel_base = actual_pos;
			default: rel_base = s.busy ? s.cur.target : s.base;
		endcase
		nm = setpoint_in;
		nm.pass = control_word[CW_PASS];
		if (control_word[CW_RELATIVE])
			nm.target = rel_base + setpoint_in.target;

		// only act once per application cycle
		if (tick)
		begin
			next_s.mode_on = mode_now;
			next_s.start_prev = control_word[CW_START];

			if (!mode_now)
			begin
				// another mode owns the drive: drop all motion
				next_s.busy = 1'b0;
				next_s.pend_valid = 1'b0;
				next_s.speed = '0;
				next_s.accel_now = '0;
				next_s.ack = 1'b0;
			end
			else if (s.busy)
			begin
				// profile limits
				vlim = umin(umin(s.cur.speed, cfg.max_prof_speed), cfg.max_motor_speed);
				acc_lim = umin(s.cur.accel, cfg.max_accel);
				dec_lim = umin(s.cur.decel, cfg.max_decel);
				if (halt && cfg.halt_opt == HALT_QUICK)
					dec_lim = umin(cfg.quick_decel, cfg.max_decel);
				// hold profile speed through a passed target
				vend = (s.cur.pass && s.pend_valid) ? vlim : umin(s.cur.end_speed, vlim);
				rem = dist_of(s.cur.target, s.pos);
				want_dir = (s.cur.target > s.pos);
				// brake when stopping distance exceeds the remainder
				lhs = 66'(s.speed) * 66'(s.speed);
				rhs = 66'(vend) * 66'(vend) + ((66'(dec_lim) * 66'(rem)) << 1);
				brake = halt || (s.speed != '0 && s.dir != want_dir)
					|| (lhs > rhs) || (s.speed > vlim);

				// acceleration, jerk limited on request
				a_want = brake ? dec_lim : acc_lim;
				if (cfg.ramp_type == RAMP_JERK)
				begin
					a_now = (brake != s.braking) ? '0 : s.accel_now;
					jstep = cfg.jerk[{brake, a_now > a_want}];
					if (a_now > a_want)
						a_now = (a_now - a_want > jstep) ? a_now - jstep : a_want;
					else
						a_now = (a_want - a_now > jstep) ? a_now + jstep : a_want;
				end
				else
				begin
					a_now = a_want;
				end
				next_s.accel_now = a_now;
				next_s.braking = brake;

				// speed update within limits
				sum = 33'(s.speed) + 33'(a_now);
				if (brake)
					nspeed = (s.speed > a_now) ? s.speed - a_now : '0;
				else
					nspeed = umin(sum[32] ? 32'hFFFF_FFFF : sum[31:0], vlim);
				if (s.speed == '0)
					next_s.dir = want_dir;
				next_s.speed = nspeed;

				// position update or arrival
				if (next_s.dir == want_dir && rem <= nspeed)
				begin
					next_s.pos = s.cur.target;
					// sampled position as base when not stopping
					next_s.base = (s.cur.end_speed != '0) ? actual_pos : s.cur.target;
					if (s.pend_valid)
					begin
						// next queued target
						next_s.cur = s.pend;
						next_s.pend_valid = 1'b0;
						if (!s.cur.pass)
							next_s.speed = '0;
					end
					else
					begin
						next_s.busy = 1'b0;
						next_s.speed = '0;
						next_s.accel_now = '0;
					end
				end
				else if (next_s.dir)
				begin
					next_s.pos = s.pos + $signed(nspeed);
				end
				else
				begin
					next_s.pos = s.pos - $signed(nspeed);
				end
			end

			// acknowledge release
			if (!control_word[CW_START] && !next_s.pend_valid)
				next_s.ack = 1'b0;

			// new set-point acceptance
			if (start_edge && !s.ack)
			begin
				if (outside(nm.target, cfg))
				begin
					next_s.limit_hit = 1'b1;
				end
				else if (imm || !next_s.busy)
				begin
					// direct load bypasses and flushes the queue
					next_s.cur = nm;
					next_s.busy = 1'b1;
					next_s.pend_valid = 1'b0;
					next_s.ack = 1'b1;
					next_s.limit_hit = 1'b0;
				end
				else if (!next_s.pend_valid)
				begin
					// single queue slot
					next_s.pend = nm;
					next_s.pend_valid = 1'b1;
					next_s.ack = 1'b1;
					next_s.limit_hit = 1'b0;
				end
				if (next_s.ack && !s.ack)
				begin
					next_s.reached = 1'b0;
					next_s.win_cnt = '0;
					next_s.start_clear = (clr_mode == CLR_ON_ACK);
				end
			end

			// target window with dwell, or halted standstill
			if (halt && next_s.speed == '0 && mode_now)
			begin
				next_s.reached = 1'b1;
			end
			else if (!next_s.busy && mode_now
				&& dist_of(actual_pos, s.cur.target) <= cfg.pos_window)
			begin
				if (s.win_cnt != 32'hFFFF_FFFF)
					next_s.win_cnt = s.win_cnt + 32'h1;
				if (s.win_cnt >= cfg.window_ticks)
					next_s.reached = 1'b1;
			end
			else
			begin
				next_s.win_cnt = '0;
				next_s.reached = 1'b0;
			end
			if (next_s.reached && !s.reached && clr_mode == CLR_ON_REACHED)
				next_s.start_clear = 1'b1;

			// following error with timeout
			if (cfg.closed_loop && dist_of(actual_pos, s.pos) > cfg.fe_window)
			begin
				if (s.fe_cnt != 32'hFFFF_FFFF)
					next_s.fe_cnt = s.fe_cnt + 32'h1;
				next_s.fe = (s.fe_cnt >= cfg.fe_ticks);
			end
			else
			begin
				next_s.fe_cnt = '0;
				next_s.fe = 1'b0;
			end
		end
	end

	// ------------------------------------------------------------------
	// registers
	// ------------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			s <= '0;
		else
			s <= next_s;
	end

	// ------------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------------
	// status bits registered, except limit_exceeded, which also compares demand position with cfg limits
	assign status.target_reached = s.reached;
	assign status.limit_exceeded = s.limit_hit || outside(s.pos, cfg);
	assign status.setpoint_ack = s.ack;
	assign status.following_error = s.fe;
	assign demand_pos = s.pos;
	assign demand_speed = s.speed;
	assign start_clear = s.start_clear;

endmodule

`default_nettype wire

// ==== ppc_ctrl_properties.sv ====
/* ppc_ctrl_properties: port checks for ppc_ctrl.
   Assumes: bound into ppc_ctrl, TICK_CYCLES of 8 or more. */
`timescale 1ns/100ps
`default_nettype none
module ppc_props #(
	parameter int TICK_CYCLES = 8
) (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// command objects and feedback
	input wire logic [7:0] operating_mode_select,
	input wire logic [15:0] control_word,
	input wire ppc_pkg::ppc_move_t setpoint_in,
	input wire ppc_pkg::ppc_cfg_t cfg,
	input wire logic signed [31:0] actual_pos,
	// status and profile
	input wire ppc_pkg::ppc_status_t status,
	input wire logic signed [31:0] demand_pos,
	input wire logic [31:0] demand_speed,
	input wire logic start_clear
);
	import ppc_pkg::*;
	int gap;
	logic ack_q;
	// clocks since acknowledge last moved
	always_ff @(posedge clk)
	begin
		ack_q <= status.setpoint_ack;
		if (sys_rst || ack_q != status.setpoint_ack)
			gap <= 0;
		else if (gap < 1000)
			gap <= gap + 1;
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	ack_gap_a: assert property (ack_q != status.setpoint_ack |-> gap >= TICK_CYCLES - 1)
		else $error("acknowledge moved twice in one cycle");
	clr_pulse_a: assert property (start_clear |=> !start_clear)
		else $error("start clear longer than one clock");
	ack_cause_a: assert property ($rose(status.setpoint_ack) |->
		$past(control_word[CW_START])
		&& (!status.target_reached || $past(control_word[CW_HALT])))
		else $error("acknowledge without start");
	ack_drop_a: assert property ($fell(status.setpoint_ack) |-> !$past(control_word[CW_START])
		|| $past(operating_mode_select) != MODE_PROFILE_POS)
		else $error("acknowledge dropped with start high");
	limit_flag_a: assert property (demand_pos > cfg.limit_max ||
		demand_pos < cfg.limit_min |-> status.limit_exceeded)
		else $error("limit flag missing");
	speed_cap_a: assert property (demand_speed <= cfg.max_prof_speed &&
		demand_speed <= cfg.max_motor_speed)
		else $error("speed above cap");
	accel_cap_a: assert property (demand_speed > $past(demand_speed) |->
		demand_speed - $past(demand_speed) <= cfg.max_accel)
		else $error("acceleration above cap");
	fe_loop_a: assert property ($rose(status.following_error) |-> $past(cfg.closed_loop))
		else $error("following error in open loop");
	cover property ($rose(status.setpoint_ack));
	cover property ($rose(status.target_reached));
	cover property (start_clear);
endmodule
bind ppc_ctrl ppc_props #(.TICK_CYCLES(TICK_CYCLES)) u_props (.clk(clk), .sys_rst(sys_rst),
	.operating_mode_select(operating_mode_select), .control_word(control_word),
	.setpoint_in(setpoint_in), .cfg(cfg), .actual_pos(actual_pos), .status(status),
	.demand_pos(demand_pos), .demand_speed(demand_speed), .start_clear(start_clear));
`default_nettype wire

// ==== ppc_master_model.sv ====
/* ppc_master: fieldbus master writing objects, plus position feedback.
   Assumes: bench requests change at clk rising edge. */
`timescale 1ns/100ps
`default_nettype none
module ppc_master (
	// clock
	input wire logic clk,
	// bench requests
	input wire logic [7:0] req_mode,
	input wire logic [15:0] req_cw,
	input wire logic signed [31:0] req_target,
	input wire logic signed [31:0] fb_off,
	input wire logic signed [31:0] demand_pos,
	// objects toward the device
	output logic [7:0] operating_mode_select,
	output logic [15:0] control_word,
	output ppc_pkg::ppc_move_t setpoint_in,
	output logic signed [31:0] actual_pos
);
	import ppc_pkg::*;
	// object writes land one clock after the request
	always_ff @(posedge clk)
	begin
		operating_mode_select <= req_mode;
		control_word <= req_cw;
		setpoint_in <= '{req_target, 32'h14, 32'h0, 32'h5, 32'h5, req_cw[CW_PASS]};
	end
	// encoder follows demand in the same clock, plus optional offset fb_off
	assign actual_pos = demand_pos + fb_off;
endmodule
`default_nettype wire

// ==== ppc_pkg.sv ====
/*
 * ppc_pkg: shared constants, carrier structs and timing figures for the
 * profile position set-point controller.
 * Assumes: a single 200 MHz clock; all users import ppc_pkg::*.
 */
package ppc_pkg;

	// ----------------------------------------------------------------
	// operating mode and command word bit positions
	// ----------------------------------------------------------------
	localparam logic [7:0] MODE_PROFILE_POS = 8'h01;
	localparam int CW_START = 4;
	localparam int CW_IMMEDIATE = 5;
	localparam int CW_RELATIVE = 6;
	localparam int CW_HALT = 8;
	localparam int CW_PASS = 9;

	// ----------------------------------------------------------------
	// option codes
	// ----------------------------------------------------------------
	// positioning option code: relative reference field and auto-clear field
	localparam int POC_REL_LSB = 0;
	localparam int POC_CLR_LSB = 4;
	localparam logic [1:0] REL_PREV_TARGET = 2'h0;
	localparam logic [1:0] REL_DEMAND = 2'h1;
	localparam logic [1:0] REL_ACTUAL = 2'h2;
	localparam logic [1:0] CLR_NONE = 2'h0;
	localparam logic [1:0] CLR_ON_ACK = 2'h1;
	localparam logic [1:0] CLR_ON_REACHED = 2'h2;
	// halt option code selecting the quick stop deceleration
	localparam logic [15:0] HALT_QUICK = 16'h0002;
	// ramp types
	localparam logic [15:0] RAMP_TRAPEZOID = 16'h0000;
	localparam logic [15:0] RAMP_JERK = 16'h0003;
	localparam int JERK_COUNT = 4;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 5;
	localparam int TICK_PERIOD_NS = 1000000;
	localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;

	// ----------------------------------------------------------------
	// carrier types
	// ----------------------------------------------------------------
	// one set-point with its own profile parameters
	typedef struct packed {
		logic signed [31:0] target;
		logic [31:0] speed;
		logic [31:0] end_speed;
		logic [31:0] accel;
		logic [31:0] decel;
		logic pass;
	} ppc_move_t;

	// configuration objects that steer the profile
	typedef struct packed {
		logic [31:0] max_prof_speed;
		logic [31:0] max_motor_speed;
		logic [31:0] max_accel;
		logic [31:0] max_decel;
		logic [31:0] quick_decel;
		logic [15:0] halt_opt;
		logic [15:0] pos_opt;
		logic [15:0] ramp_type;
		logic [JERK_COUNT-1:0][31:0] jerk;
		logic signed [31:0] limit_min;
		logic signed [31:0] limit_max;
		logic [31:0] pos_window;
		logic [31:0] window_ticks;
		logic [31:0] fe_window;
		logic [31:0] fe_ticks;
		logic closed_loop;
	} ppc_cfg_t;

	// status word bits reported by the block
	typedef struct packed {
		logic following_error;
		logic setpoint_ack;
		logic limit_exceeded;
		logic target_reached;
	} ppc_status_t;

endpackage

// ==== ppc_tick.sv ====
/*
 * ppc_tick: application cycle pulse generator.
 * Assumes: clk free running, sys_rst synchronous active high.
 */
`timescale 1ns/100ps
`default_nettype none

module ppc_tick #(
	parameter int CYCLES = ppc_pkg::TICK_CYCLES
) (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// one-cycle pulse every CYCLES clocks
	output logic tick
);
	import ppc_pkg::*;

	typedef struct packed {
		logic [31:0] cnt;
		logic tick;
	} ppc_tick_state_t;

	localparam logic [31:0] LAST = 32'(CYCLES - 1);

	ppc_tick_state_t s;
	ppc_tick_state_t next_s;

	// count up the cycle and pulse on wrap
	always_comb
	begin
		next_s = s;
		next_s.tick = 1'b0;
		if (s.cnt == LAST)
		begin
			next_s.cnt = '0;
			next_s.tick = 1'b1;
		end
		else
		begin
			next_s.cnt = s.cnt + 32'h1;
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			s <= '0;
		else
			s <= next_s;
	end

	assign tick = s.tick;

endmodule

`default_nettype wire

// ==== profile_position_setpoint_control_tb.sv ====
/* profile_position_setpoint_control_tb: self-checking bench for ppc_ctrl.
   Assumes: ppc_pkg, ppc_ctrl, ppc_master and the checker compiled first. */
`timescale 1ns/100ps
`default_nettype none
module profile_position_setpoint_control_tb;
	import ppc_pkg::*;
	localparam int T = 8;
	typedef struct {logic signed [31:0] tgt; logic rel; logic signed [31:0] exp;} ppc_row_t;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [7:0] req_mode = 8'h01;
	logic [15:0] req_cw = 16'h0000;
	logic signed [31:0] req_target = 32'sh0;
	logic signed [31:0] fb_off = 32'sh0;
	logic [7:0] operating_mode_select;
	logic [15:0] control_word;
	ppc_move_t setpoint_in;
	ppc_cfg_t cfg;
	logic signed [31:0] actual_pos;
	logic signed [31:0] demand_pos;
	logic [31:0] demand_speed;
	ppc_status_t status;
	logic start_clear;
	int n_clr = 0;
	int k = 0;
	int failures = 0;
	int n_tests = 0;
	ppc_row_t rows [4] = '{'{32'sh64, 1'h0, 32'sh64}, '{32'sh32, 1'h1, 32'sh96},
		'{-32'sh28, 1'h0, -32'sh28}, '{-32'shA, 1'h1, -32'sh32}};
	// clock and parts
	always #2.5 clk = ~clk;
	ppc_master u_ppc_master (.clk(clk), .req_mode(req_mode), .req_cw(req_cw),
		.req_target(req_target), .fb_off(fb_off), .demand_pos(demand_pos),
		.operating_mode_select(operating_mode_select), .control_word(control_word),
		.setpoint_in(setpoint_in), .actual_pos(actual_pos));
	ppc_ctrl #(.TICK_CYCLES(T)) u_ppc_ctrl (.clk(clk), .sys_rst(sys_rst),
		.operating_mode_select(operating_mode_select), .control_word(control_word),
		.setpoint_in(setpoint_in), .cfg(cfg), .actual_pos(actual_pos), .status(status),
		.demand_pos(demand_pos), .demand_speed(demand_speed), .start_clear(start_clear));
	// count clear requests
	always @(posedge clk)
		if (start_clear)
			n_clr <= n_clr + 1;
	task automatic chk_bit(input string name, input logic exp, input logic got);
		n_tests++;
		if (got !== exp)
		begin
			failures++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic chk_pos(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp)
		begin
			failures++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic ticks(input int n);
		repeat (n * T) @(posedge clk);
	endtask
	// bounded wait on one status bit
	task automatic wait_st(input int idx, input logic v);
		int i;
		i = 0;
		do
		begin
			@(posedge clk);
			i++;
		end
		while (status[idx] !== v && i < 4000);
		if (status[idx] !== v)
		begin
			failures++;
			$display("Error status bit %0d expected %h seen %h", idx, v, status[idx]);
			end_sim();
		end
	endtask
	// one start handshake: edge, acknowledge, release
	task automatic go(input logic signed [31:0] tgt, input logic [15:0] cw);
		req_target <= tgt;
		req_cw <= cw;
		ticks(2);
		req_cw <= cw | 16'h0010;
		wait_st(2, 1'b1);
		req_cw <= cw;
		wait_st(2, 1'b0);
	endtask
	initial
	begin
		cfg = '0;
		cfg.max_prof_speed = 32'h1E;
		cfg.max_motor_speed = 32'h10;
		cfg.max_accel = 32'h4;
		cfg.max_decel = 32'h8;
		cfg.quick_decel = 32'h10;
		cfg.pos_opt = 16'h0010;
		cfg.limit_min = -32'sh3E8;
		cfg.limit_max = 32'sh3E8;
		cfg.window_ticks = 32'h2;
		cfg.fe_window = 32'hA;
		cfg.fe_ticks = 32'h1;
		repeat (5) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		chk_bit("reset status", 1'b1, status === 4'h0);
		chk_pos("reset demand", 32'sh0, demand_pos);
		// ordinary absolute and relative moves
		foreach (rows[i])
		begin
			go(rows[i].tgt, {9'h0, rows[i].rel, 6'h0});
			chk_pos("first speed", 32'h4, demand_speed);
			wait_st(0, 1'b1);
			chk_pos("row position", rows[i].exp, demand_pos);
		end
		// target beyond software limit
		req_target <= 32'sh1388;
		ticks(2);
		req_cw <= 16'h0010;
		ticks(4);
		chk_bit("refused ack", 1'b0, status.setpoint_ack);
		chk_bit("limit flag", 1'b1, status.limit_exceeded);
		// buffered: one slot, third set-point dropped
		go(32'sh1F4, 16'h0000);
		req_target <= 32'sh258;
		ticks(1);
		req_cw <= 16'h0010;
		wait_st(2, 1'b1);
		req_cw <= 16'h0000;
		ticks(2);
		chk_bit("queue full ack", 1'b1, status.setpoint_ack);
		chk_pos("capped speed", 32'h10, demand_speed);
		req_target <= 32'sh2BC;
		req_cw <= 16'h0010;
		ticks(2);
		req_cw <= 16'h0000;
		wait_st(2, 1'b0);
		wait_st(0, 1'b1);
		chk_pos("queued position", 32'sh258, demand_pos);
		// immediate change in mid move
		go(32'sh384, 16'h0020);
		ticks(2);
		go(32'sh0, 16'h0020);
		chk_bit("bypass short", 1'b1, demand_pos < 32'sh320);
		wait_st(0, 1'b1);
		chk_pos("immediate position", 32'sh0, demand_pos);
		// pass through a queued target at speed
		go(32'sh12C, 16'h0200);
		req_target <= 32'sh1F4;
		ticks(1);
		req_cw <= 16'h0210;
		wait_st(2, 1'b1);
		req_cw <= 16'h0200;
		wait_st(2, 1'b0);
		chk_pos("pass speed", 32'h10, demand_speed);
		wait_st(0, 1'b1);
		chk_pos("pass position", 32'sh1F4, demand_pos);
		// halt short of target, then resume
		go(-32'sh384, 16'h0000);
		req_cw <= 16'h0100;
		wait_st(0, 1'b1);
		chk_bit("halted short", 1'b1, demand_pos != -32'sh384);
		req_cw <= 16'h0000;
		wait_st(0, 1'b0);
		wait_st(0, 1'b1);
		chk_pos("resumed position", -32'sh384, demand_pos);
		// mode entry with start already high
		req_mode <= 8'h00;
		req_target <= 32'shC8;
		req_cw <= 16'h0010;
		ticks(2);
		k = n_clr;
		req_mode <= 8'h01;
		wait_st(2, 1'b1);
		req_cw <= 16'h0000;
		wait_st(0, 1'b1);
		chk_pos("mode entry position", 32'shC8, demand_pos);
		chk_bit("auto clear pulse", 1'b1, n_clr == k + 1);
		// jerk limited ramp, clear request on reached
		cfg.ramp_type <= RAMP_JERK;
		cfg.jerk <= {4{32'h2}};
		cfg.pos_opt <= 16'h0020;
		k = n_clr;
		go(32'sh1F4, 16'h0000);
		chk_pos("jerk first speed", 32'h2, demand_speed);
		wait_st(0, 1'b1);
		chk_pos("jerk position", 32'sh1F4, demand_pos);
		ticks(1);
		chk_bit("reached clear pulse", 1'b1, n_clr == k + 1);
		// feedback far ahead of demand in closed loop
		fb_off <= 32'sh1388;
		cfg.closed_loop <= 1'b1;
		wait_st(3, 1'b1);
		// reset in mid run clears all status
		sys_rst <= 1'b1;
		repeat (5) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		chk_bit("rerun status", 1'b1, status === 4'h0);
		chk_pos("rerun speed", 32'h0, demand_speed);
		end_sim();
	end
endmodule
`default_nettype wire
